// ### verilog/pbl_defs.svh
// register offsets, field positions and timing counts of the bootstrap loader
// assumes a 100 MHz core clock; included by its bare name
`ifndef PBL_DEFS_SVH
`define PBL_DEFS_SVH

`define PBL_REG_CTRL 2'h0
`define PBL_REG_STAT 2'h1
`define PBL_REG_SUM 2'h2
`define PBL_REG_ADDR 2'h3

`define PBL_CTRL_LOAD 0
`define PBL_CTRL_NOGO 1

`define PBL_STAT_BUSY 0
`define PBL_STAT_STATE 1
`define PBL_STAT_CONFLICT 4
`define PBL_STAT_GONE 5

`define PBL_CLK_MHZ 100
`define PBL_MC_TIME_NS 1000
`define PBL_GO_TIME_NS 200
`define PBL_MC_CYC ((`PBL_MC_TIME_NS * `PBL_CLK_MHZ + 999) / 1000)
`define PBL_GO_CYC ((`PBL_GO_TIME_NS * `PBL_CLK_MHZ + 999) / 1000)

`define PBL_HALF_WORDS 512
`define PBL_FULL_WORDS 1024
`define PBL_SEL_SHIFT 2
`define PBL_PRE_TOP 16'h001c
`define PBL_FIFO_DEPTH 16
`define PBL_MEM_WORDS 65536

`endif

// ### verilog/pbl_pkg.sv
// types shared by the bootstrap loader and its buffer
// assumes nothing beyond a SystemVerilog compiler
package pbl_pkg;

  typedef enum logic [2:0] {
    PBL_IDLE  = 3'b000,
    PBL_MCLR  = 3'b001,
    PBL_CLEAR = 3'b010,
    PBL_PRE   = 3'b011,
    PBL_BOOT  = 3'b100,
    PBL_DRAIN = 3'b101,
    PBL_GO    = 3'b110
  } pbl_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } pbl_mem_word_t;

endpackage : pbl_pkg

// ### verilog/pbl_loader.sv
// bootstrap loader control: word buffer and loader top
// assumes synchronous switch/jumper inputs and a one-cycle-latency store
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pbl_defs.svh"

// ---------------------------------------------------------------
// word buffer
// ---------------------------------------------------------------
module pbl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = `PBL_FIFO_DEPTH
) (
  input wire logic clk_i,                  // core clock
  input wire logic rst_n_i,                // async reset, low
  input wire logic ce_i,                   // clock enable
  input wire logic in_valid_i,             // word offered
  output logic in_ready_o,                 // room for a word
  input wire logic [WIDTH-1:0] in_data_i,  // word in
  output logic out_valid_o,                // word available
  input wire logic out_ready_i,            // drain takes word
  output logic [WIDTH-1:0] out_data_o      // word out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  assign in_ready_o = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_ff != '0;
  assign out_data_o = mem_ff[rd_ff];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else if (ce_i) begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
      if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule : pbl_fifo

// ---------------------------------------------------------------
// loader top
// ---------------------------------------------------------------
// Behaviour
// - power-up loading starts a load at reset release and power switch-on
// - clear jumper out clears memory first; start jumper out enables power-up
// - preamble jumper out loads the protect preamble before the bootstrap
// - both jumpers in: any trigger loads without clearing, and starts only if the go jumper is in
// - master clear jumper in: pulse master clear on power and each load
// - go jumper in: pulse go after loading, unless the control no-go bit is set
// - override jumper in: hold protect override while busy, with clear/go enabled
// - console request acts only with console enable switch up
// - local button loads regardless of console enable switch
// - remote line low requests a load, independent of console switch
// - load address is sixteen switch bits, depressed sets the bit
// - bootstrap start word is select switch value times four
// - full capacity jumper limits bootstrap (not preamble) store word range to 1024, else 512
// - go jumper out: still load, but never start execution
module pbl_loader #(
  parameter int MEM_WORDS = `PBL_MEM_WORDS,
  parameter int BOOT_WORDS = 64,
  parameter int PRE_WORDS = 28,
  parameter int PRE_ROM_BASE = 960
) (
  input wire logic CLK_I,                               // 100 MHz clock
  input wire logic ARST_N_I,                            // async reset, low
  input wire logic CE_I,                                // clock enable
  input wire logic PWR_ON_I,                            // power switch on
  input wire logic CONSOLE_LOAD_I,                      // console button
  input wire logic LOCAL_LOAD_BUTTON_I,                 // on-card button
  input wire logic REMOTE_LOAD_N_I,                     // remote line, low
  input wire logic CONSOLE_LOAD_ENABLE_SWITCH_I,        // 1 = up
  input wire logic [7:0] LOAD_ADDRESS_LOW_SWITCHES_I,   // bits 7..0
  input wire logic [7:0] LOAD_ADDRESS_HIGH_SWITCHES_I,  // bits 15..8
  input wire logic [7:0] BOOTSTRAP_SELECT_SWITCHES_I,   // start / 4
  input wire logic HALF_CAPACITY_JUMPER_I,              // 512 words
  input wire logic FULL_CAPACITY_JUMPER_I,              // 1024 words
  input wire logic CLEAR_MEMORY_ENABLE_JUMPER_I,        // 1 = fitted
  input wire logic POWER_UP_START_ENABLE_JUMPER_I,      // 1 = fitted
  input wire logic PROTECT_PREAMBLE_ENABLE_JUMPER_I,    // 1 = fitted
  input wire logic MASTER_CLEAR_JUMPER_I,               // 1 = fitted
  input wire logic GO_JUMPER_I,                         // 1 = fitted
  input wire logic PROTECT_OVERRIDE_JUMPER_I,           // 1 = fitted
  output logic [9:0] ROM_ADDR_O,                        // store address
  output logic ROM_RD_O,                                // store read
  input wire logic [15:0] ROM_DATA_I,                   // data next cycle
  output logic MEM_WR_O,                                // memory write
  output logic [15:0] MEM_ADDR_O,                       // memory address
  output logic [15:0] MEM_DATA_O,                       // memory data
  input wire logic MEM_READY_I,                         // write taken
  output logic LOADER_MASTER_CLEAR_O,                   // master clear
  output logic LOADER_GO_O,                             // go to cpu
  output logic PROTECT_OVERRIDE_O,                      // protect override
  input wire logic [1:0] REG_ADDR_I,                    // register index
  input wire logic [15:0] REG_WDATA_I,                  // write data
  input wire logic REG_WR_I,                            // write strobe
  input wire logic REG_RD_I,                            // read strobe
  output logic [15:0] REG_RDATA_O                       // read data
);
  localparam logic [7:0] MC_CYC = 8'(`PBL_MC_CYC);
  localparam logic [7:0] GO_CYC = 8'(`PBL_GO_CYC);

  if (BOOT_WORDS < 1 || PRE_WORDS < 1 || PRE_WORDS > 28 ||
      MEM_WORDS < 1 || MEM_WORDS > `PBL_MEM_WORDS ||
      PRE_ROM_BASE + PRE_WORDS > `PBL_FULL_WORDS ||
      `PBL_MC_CYC > 256 || `PBL_GO_CYC > 256) begin : g_bad_param
    $error("loader parameters out of range");
  end

  pbl_pkg::pbl_state_t state_ff;
  logic first_ff, pwr_prev_ff, con_prev_ff, loc_prev_ff, rem_prev_ff;
  logic cfg_load_ff, cfg_clr_ff, cfg_pre_ff, cfg_go_ff, nogo_ff, gone_ff;
  logic [7:0] tim_ff;
  logic [16:0] cnt_ff;
  logic [9:0] rom_ff;
  logic [15:0] madr_ff, pend_madr_ff, sum_ff;
  logic rd_ff, push_ff, pend_boot_ff;
  logic pup_en, pup_trig, any_trig, start, issue, last, drained, pwr_app;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [15:0] load_addr;
  logic [10:0] lim;
  pbl_pkg::pbl_mem_word_t fifo_in, fifo_out, mem_ff;

  // ---------------------------------------------------------------
  // triggers
  // ---------------------------------------------------------------
  assign load_addr = {LOAD_ADDRESS_HIGH_SWITCHES_I,
                      LOAD_ADDRESS_LOW_SWITCHES_I};
  assign pup_en = !POWER_UP_START_ENABLE_JUMPER_I;
  assign pwr_app = first_ff | (PWR_ON_I & !pwr_prev_ff);
  assign pup_trig = pup_en & pwr_app;
  assign any_trig = pup_trig
    | (CONSOLE_LOAD_I & !con_prev_ff & CONSOLE_LOAD_ENABLE_SWITCH_I)
    | (LOCAL_LOAD_BUTTON_I & !loc_prev_ff)
    | (!REMOTE_LOAD_N_I & rem_prev_ff)
    | (REG_WR_I && REG_ADDR_I == `PBL_REG_CTRL
       && REG_WDATA_I[`PBL_CTRL_LOAD]);
  // a trigger while busy is dropped, not queued
  assign start = any_trig && state_ff == pbl_pkg::PBL_IDLE;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      first_ff <= 1'b1;
      pwr_prev_ff <= 1'b1;
      con_prev_ff <= 1'b1;
      loc_prev_ff <= 1'b1;
      rem_prev_ff <= 1'b0;
    end else if (CE_I) begin
      first_ff <= 1'b0;
      pwr_prev_ff <= PWR_ON_I;
      con_prev_ff <= CONSOLE_LOAD_I;
      loc_prev_ff <= LOCAL_LOAD_BUTTON_I;
      rem_prev_ff <= REMOTE_LOAD_N_I;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign lim = FULL_CAPACITY_JUMPER_I ? 11'(`PBL_FULL_WORDS)
                                      : 11'(`PBL_HALF_WORDS);
  assign issue = (state_ff == pbl_pkg::PBL_PRE
                  || (state_ff == pbl_pkg::PBL_BOOT
                      && {1'b0, rom_ff} < lim))
                 && !rd_ff && !push_ff && fifo_in_ready;
  assign last = (state_ff == pbl_pkg::PBL_PRE)
    ? cnt_ff == 17'(PRE_WORDS - 1)
    : (cnt_ff == 17'(BOOT_WORDS - 1) || {1'b0, rom_ff} == lim - 1'b1);
  assign drained = !rd_ff && !push_ff && !fifo_out_valid && !MEM_WR_O;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_ff <= pbl_pkg::PBL_IDLE;
      tim_ff <= 8'h00;
      cnt_ff <= 17'h00000;
      rom_ff <= 10'h000;
      madr_ff <= 16'h0000;
      cfg_load_ff <= 1'b0;
      cfg_clr_ff <= 1'b0;
      cfg_pre_ff <= 1'b0;
      cfg_go_ff <= 1'b0;
      LOADER_MASTER_CLEAR_O <= 1'b0;
      LOADER_GO_O <= 1'b0;
      gone_ff <= 1'b0;
    end else if (CE_I) begin
      case (state_ff)
        pbl_pkg::PBL_IDLE: begin
          // power application alone still gets its master clear
          if (start || (pwr_app && MASTER_CLEAR_JUMPER_I)) begin
            state_ff <= pbl_pkg::PBL_MCLR;
            tim_ff <= MC_CYC - 8'h01;
            cfg_load_ff <= start;
            cfg_clr_ff <= !CLEAR_MEMORY_ENABLE_JUMPER_I;
            cfg_pre_ff <= !PROTECT_PREAMBLE_ENABLE_JUMPER_I;
            cfg_go_ff <= GO_JUMPER_I;
            LOADER_MASTER_CLEAR_O <= MASTER_CLEAR_JUMPER_I;
            gone_ff <= 1'b0;
          end
        end
        pbl_pkg::PBL_MCLR: begin
          if (tim_ff == 8'h00) begin
            LOADER_MASTER_CLEAR_O <= 1'b0;
            cnt_ff <= 17'h00000;
            madr_ff <= 16'h0000;
            rom_ff <= 10'(PRE_ROM_BASE);
            if (!cfg_load_ff) state_ff <= pbl_pkg::PBL_IDLE;
            else if (cfg_clr_ff) state_ff <= pbl_pkg::PBL_CLEAR;
            else if (cfg_pre_ff) state_ff <= pbl_pkg::PBL_PRE;
            else begin
              state_ff <= pbl_pkg::PBL_BOOT;
              rom_ff <= {BOOTSTRAP_SELECT_SWITCHES_I, 2'b00};
              madr_ff <= load_addr;
            end
          end else begin
            tim_ff <= tim_ff - 8'h01;
          end
        end
        pbl_pkg::PBL_CLEAR: begin
          if (fifo_in_ready) begin
            madr_ff <= madr_ff + 16'h0001;
            cnt_ff <= cnt_ff + 17'h00001;
            if (cnt_ff == 17'(MEM_WORDS - 1)) begin
              cnt_ff <= 17'h00000;
              madr_ff <= 16'h0000;
              if (cfg_pre_ff) state_ff <= pbl_pkg::PBL_PRE;
              else begin
                state_ff <= pbl_pkg::PBL_BOOT;
                rom_ff <= {BOOTSTRAP_SELECT_SWITCHES_I, 2'b00};
                madr_ff <= load_addr;
              end
            end
          end
        end
        pbl_pkg::PBL_PRE, pbl_pkg::PBL_BOOT: begin
          if (state_ff == pbl_pkg::PBL_BOOT && {1'b0, rom_ff} >= lim) begin
            state_ff <= pbl_pkg::PBL_DRAIN;
          end else if (issue) begin
            rom_ff <= rom_ff + 10'h001;
            madr_ff <= madr_ff + 16'h0001;
            cnt_ff <= cnt_ff + 17'h00001;
            if (last && state_ff == pbl_pkg::PBL_PRE) begin
              state_ff <= pbl_pkg::PBL_BOOT;
              cnt_ff <= 17'h00000;
              rom_ff <= {BOOTSTRAP_SELECT_SWITCHES_I, 2'b00};
              madr_ff <= load_addr;
            end else if (last) begin
              state_ff <= pbl_pkg::PBL_DRAIN;
            end
          end
        end
        pbl_pkg::PBL_DRAIN: begin
          if (drained) begin
            if (cfg_go_ff && !nogo_ff) begin
              state_ff <= pbl_pkg::PBL_GO;
              tim_ff <= GO_CYC - 8'h01;
              LOADER_GO_O <= 1'b1;
              gone_ff <= 1'b1;
            end else begin
              state_ff <= pbl_pkg::PBL_IDLE;
            end
          end
        end
        pbl_pkg::PBL_GO: begin
          if (tim_ff == 8'h00) begin
            LOADER_GO_O <= 1'b0;
            state_ff <= pbl_pkg::PBL_IDLE;
          end else begin
            tim_ff <= tim_ff - 8'h01;
          end
        end
        default: begin
          state_ff <= pbl_pkg::PBL_IDLE;
        end
      endcase
    end
  end

  // override follows the busy state one cycle late: second clear-pulse cycle through one cycle after the go pulse
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PROTECT_OVERRIDE_O <= 1'b0;
    end else if (CE_I) begin
      PROTECT_OVERRIDE_O <= PROTECT_OVERRIDE_JUMPER_I
        && (MASTER_CLEAR_JUMPER_I || GO_JUMPER_I)
        && state_ff != pbl_pkg::PBL_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // store read pipeline
  // ---------------------------------------------------------------
  // one read in flight at a time: the room checked at issue is still
  // there when the word lands two cycles later
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ROM_RD_O <= 1'b0;
      ROM_ADDR_O <= 10'h000;
      rd_ff <= 1'b0;
      push_ff <= 1'b0;
      pend_madr_ff <= 16'h0000;
      pend_boot_ff <= 1'b0;
      sum_ff <= 16'h0000;
    end else if (CE_I) begin
      ROM_RD_O <= issue;
      rd_ff <= issue;
      push_ff <= rd_ff;
      if (issue) begin
        ROM_ADDR_O <= rom_ff;
        pend_madr_ff <= madr_ff;
        pend_boot_ff <= state_ff == pbl_pkg::PBL_BOOT;
      end
      if (start) sum_ff <= 16'h0000;
      else if (push_ff && pend_boot_ff) sum_ff <= sum_ff + ROM_DATA_I;
    end
  end

  assign fifo_in_valid = state_ff == pbl_pkg::PBL_CLEAR || push_ff;
  assign fifo_in.addr = push_ff ? pend_madr_ff : madr_ff;
  assign fifo_in.data = push_ff ? ROM_DATA_I : 16'h0000;

  pbl_fifo #(
    .WIDTH($bits(pbl_pkg::pbl_mem_word_t)),
    .DEPTH(`PBL_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_n_i(ARST_N_I),
    .ce_i(CE_I),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out)
  );

  // ---------------------------------------------------------------
  // memory write port
  // ---------------------------------------------------------------
  assign fifo_pop = CE_I && (!MEM_WR_O || MEM_READY_I);
  assign MEM_ADDR_O = mem_ff.addr;
  assign MEM_DATA_O = mem_ff.data;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      MEM_WR_O <= 1'b0;
      mem_ff <= '0;
    end else if (CE_I && (!MEM_WR_O || MEM_READY_I)) begin
      MEM_WR_O <= fifo_out_valid;
      if (fifo_out_valid) mem_ff <= fifo_out;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      nogo_ff <= 1'b0;
      REG_RDATA_O <= 16'h0000;
    end else if (CE_I) begin
      if (REG_WR_I && REG_ADDR_I == `PBL_REG_CTRL) begin
        nogo_ff <= REG_WDATA_I[`PBL_CTRL_NOGO];
      end
      REG_RDATA_O <= 16'h0000;
      if (REG_RD_I) begin
        case (REG_ADDR_I)
          `PBL_REG_CTRL: REG_RDATA_O[`PBL_CTRL_NOGO] <= nogo_ff;
          `PBL_REG_STAT: begin
            REG_RDATA_O[`PBL_STAT_BUSY] <= state_ff != pbl_pkg::PBL_IDLE;
            REG_RDATA_O[`PBL_STAT_STATE +: 3] <= state_ff;
            REG_RDATA_O[`PBL_STAT_CONFLICT] <=
              !PROTECT_PREAMBLE_ENABLE_JUMPER_I
              && load_addr <= `PBL_PRE_TOP;
            REG_RDATA_O[`PBL_STAT_GONE] <= gone_ff;
          end
          `PBL_REG_SUM: REG_RDATA_O <= sum_ff;
          `PBL_REG_ADDR: REG_RDATA_O <= madr_ff;
          default: REG_RDATA_O <= 16'h0000;
        endcase
      end
    end
  end
endmodule : pbl_loader

`default_nettype wire

// ### bench/pbl_host_model.sv
// host side model: bootstrap store, processor memory and control counts
// assumes the loader's store and memory write contract, one clock
`timescale 1ns/1ps
`default_nettype none
module pbl_host_model (
  input wire logic clk_i,                         // clock
  input wire logic rst_n_i,                       // reset, low
  input wire logic slow_i,                        // 1 = long write stalls
  input wire logic rom_rd_i,                      // store read
  input wire logic [9:0] rom_addr_i,              // store address
  output logic [15:0] rom_data_o,                 // store data
  input wire logic mem_wr_i,                      // write valid
  input wire pbl_pkg::pbl_mem_word_t mem_word_i,  // address and data
  output logic mem_ready_o,                       // write taken
  input wire logic mc_i,                          // master clear
  input wire logic go_i                           // go
);
  pbl_pkg::pbl_mem_word_t wq[$];
  int n_mc = 0;
  int n_go = 0;
  logic [1:0] ph_ff;
  logic mc_d_ff;
  logic go_d_ff;
  assign mem_ready_o = slow_i ? (ph_ff == 2'h3) : (ph_ff != 2'h2);
  // stale store data toggles so a late sample never looks valid
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rom_data_o <= 16'h0;
      ph_ff <= 2'h0;
      mc_d_ff <= 1'b0;
      go_d_ff <= 1'b0;
    end else begin
      rom_data_o <= rom_rd_i ? ({rom_addr_i, 6'h15} ^ 16'h3c5a) : ~rom_data_o;
      ph_ff <= ph_ff + 2'h1;
      mc_d_ff <= mc_i;
      go_d_ff <= go_i;
      if (mem_wr_i && mem_ready_o) wq.push_back(mem_word_i);
      if (mc_i && !mc_d_ff) n_mc++;
      if (go_i && !go_d_ff) n_go++;
    end
  end
endmodule : pbl_host_model
`default_nettype wire

// ### bench/pbl_loader_asserts.sv
// checker of the loader top: pulse widths, write holds, trigger handling
// assumes the bench keeps the clock enable high and both jumpers fitted
`timescale 1ns/1ps
`default_nettype none
`include "pbl_defs.svh"
module pbl_loader_chk (
  input wire logic CLK_I,                         // clock
  input wire logic ARST_N_I,                      // reset, low
  input wire logic CONSOLE_LOAD_I,                // console button
  input wire logic LOCAL_LOAD_BUTTON_I,           // on-card button
  input wire logic REMOTE_LOAD_N_I,               // remote line
  input wire logic CONSOLE_LOAD_ENABLE_SWITCH_I,  // console enable
  input wire logic MASTER_CLEAR_JUMPER_I,         // clear jumper
  input wire logic GO_JUMPER_I,                   // go jumper
  input wire logic PROTECT_OVERRIDE_JUMPER_I,     // override jumper
  input wire logic ROM_RD_O,                      // store read
  input wire logic MEM_WR_O,                      // memory write
  input wire logic [15:0] MEM_ADDR_O,             // memory address
  input wire logic [15:0] MEM_DATA_O,             // memory data
  input wire logic MEM_READY_I,                   // write taken
  input wire logic LOADER_MASTER_CLEAR_O,         // master clear
  input wire logic LOADER_GO_O,                   // go
  input wire logic PROTECT_OVERRIDE_O             // override
);
  int mc_cnt_ff;
  int go_cnt_ff;
  wire logic idle_w = MASTER_CLEAR_JUMPER_I && PROTECT_OVERRIDE_JUMPER_I
                      && !PROTECT_OVERRIDE_O;
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mc_cnt_ff <= 0;
      go_cnt_ff <= 0;
    end else begin
      mc_cnt_ff <= LOADER_MASTER_CLEAR_O ? mc_cnt_ff + 1 : 0;
      go_cnt_ff <= LOADER_GO_O ? go_cnt_ff + 1 : 0;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  chk_mc_width: assert property (
    $fell(LOADER_MASTER_CLEAR_O) |-> mc_cnt_ff == `PBL_MC_CYC)
    else $error("master clear width wrong");
  chk_go_width: assert property (
    $fell(LOADER_GO_O) |-> go_cnt_ff == `PBL_GO_CYC)
    else $error("go width wrong");
  chk_go_after_load: assert property (
    LOADER_GO_O |-> GO_JUMPER_I && !MEM_WR_O && !LOADER_MASTER_CLEAR_O)
    else $error("go at a wrong moment");
  chk_mc_jumper: assert property (
    $rose(LOADER_MASTER_CLEAR_O) |-> MASTER_CLEAR_JUMPER_I)
    else $error("master clear without jumper");
  chk_override_gate: assert property (
    PROTECT_OVERRIDE_O |-> PROTECT_OVERRIDE_JUMPER_I
      && (MASTER_CLEAR_JUMPER_I || GO_JUMPER_I))
    else $error("override without its jumpers");
  chk_override_go: assert property (
    LOADER_GO_O && PROTECT_OVERRIDE_JUMPER_I |-> PROTECT_OVERRIDE_O)
    else $error("override missing during go");
  chk_write_hold: assert property (
    MEM_WR_O && !MEM_READY_I |=> MEM_WR_O && $stable(MEM_ADDR_O)
      && $stable(MEM_DATA_O))
    else $error("write dropped or changed before accept");
  chk_rom_spacing: assert property (
    ROM_RD_O |=> !ROM_RD_O [*2])
    else $error("store reads too close");
  chk_local_start: assert property (
    $rose(LOCAL_LOAD_BUTTON_I) && idle_w |=> LOADER_MASTER_CLEAR_O)
    else $error("local button did not start");
  chk_remote_start: assert property (
    $fell(REMOTE_LOAD_N_I) && idle_w |=> LOADER_MASTER_CLEAR_O)
    else $error("remote line did not start");
  chk_console_block: assert property (
    $rose(CONSOLE_LOAD_I) && !CONSOLE_LOAD_ENABLE_SWITCH_I && idle_w
      |=> !$rose(LOADER_MASTER_CLEAR_O))
    else $error("disabled console started a load");
  chk_busy_ignore: assert property (
    $rose(LOCAL_LOAD_BUTTON_I) && PROTECT_OVERRIDE_O
      |=> !$rose(LOADER_MASTER_CLEAR_O))
    else $error("trigger during load restarted");
endmodule : pbl_loader_chk
bind pbl_loader pbl_loader_chk u_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
  .CONSOLE_LOAD_I(CONSOLE_LOAD_I), .LOCAL_LOAD_BUTTON_I(LOCAL_LOAD_BUTTON_I),
  .REMOTE_LOAD_N_I(REMOTE_LOAD_N_I),
  .CONSOLE_LOAD_ENABLE_SWITCH_I(CONSOLE_LOAD_ENABLE_SWITCH_I),
  .MASTER_CLEAR_JUMPER_I(MASTER_CLEAR_JUMPER_I), .GO_JUMPER_I(GO_JUMPER_I),
  .PROTECT_OVERRIDE_JUMPER_I(PROTECT_OVERRIDE_JUMPER_I),
  .ROM_RD_O(ROM_RD_O), .MEM_WR_O(MEM_WR_O), .MEM_ADDR_O(MEM_ADDR_O),
  .MEM_DATA_O(MEM_DATA_O), .MEM_READY_I(MEM_READY_I),
  .LOADER_MASTER_CLEAR_O(LOADER_MASTER_CLEAR_O), .LOADER_GO_O(LOADER_GO_O),
  .PROTECT_OVERRIDE_O(PROTECT_OVERRIDE_O));
`default_nettype wire

// ### bench/pbl_loader_tb_top.sv
// self-checking bench of the bootstrap loader with a host model
// assumes shortened clear length and bootstrap size set by parameters
`timescale 1ns/1ps
`default_nettype none
module pbl_loader_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, pwr = 1'b1, con = 1'b0;
  logic loc = 1'b0, rem_n = 1'b1, en = 1'b0, half = 1'b1, full = 1'b0;
  logic clr_j = 1'b1, pup_j = 1'b1, spb_j = 1'b1, mc_j = 1'b1, go_j = 1'b1;
  logic ovr_j = 1'b1, slow = 1'b0, rd_s = 1'b0, wr_s = 1'b0;
  logic [7:0] alo = 8'h0, ahi = 8'h0, sel = 8'h0;
  logic [1:0] ra = 2'h0;
  logic [15:0] wd = 16'h0, rdat, rom_data, ma, md;
  logic [9:0] rom_addr;
  logic rom_rd, mem_wr, mem_rdy, mc, go, ovr;
  int n_fail = 0, checks_done = 0;
  // bits: runs, console enable, clear, preamble, go, power-up, full, slow
  logic [7:0] cfg[8] = '{8'hbc, 8'hb5, 8'hed, 8'h3c, 8'h9c, 8'hb8, 8'hbc,
                         8'hbe};
  int kd[8] = '{0, 1, 2, 2, 3, 4, 0, 0};
  always #5 clk = ~clk;
  pbl_loader #(.MEM_WORDS(32), .BOOT_WORDS(8), .PRE_WORDS(4),
    .PRE_ROM_BASE(960)) DUT (.CLK_I(clk), .ARST_N_I(rst_n), .CE_I(ce),
    .PWR_ON_I(pwr), .CONSOLE_LOAD_I(con), .LOCAL_LOAD_BUTTON_I(loc),
    .REMOTE_LOAD_N_I(rem_n), .CONSOLE_LOAD_ENABLE_SWITCH_I(en),
    .LOAD_ADDRESS_LOW_SWITCHES_I(alo), .LOAD_ADDRESS_HIGH_SWITCHES_I(ahi),
    .BOOTSTRAP_SELECT_SWITCHES_I(sel), .HALF_CAPACITY_JUMPER_I(half),
    .FULL_CAPACITY_JUMPER_I(full), .CLEAR_MEMORY_ENABLE_JUMPER_I(clr_j),
    .POWER_UP_START_ENABLE_JUMPER_I(pup_j),
    .PROTECT_PREAMBLE_ENABLE_JUMPER_I(spb_j), .MASTER_CLEAR_JUMPER_I(mc_j),
    .GO_JUMPER_I(go_j), .PROTECT_OVERRIDE_JUMPER_I(ovr_j),
    .ROM_ADDR_O(rom_addr), .ROM_RD_O(rom_rd), .ROM_DATA_I(rom_data),
    .MEM_WR_O(mem_wr), .MEM_ADDR_O(ma), .MEM_DATA_O(md),
    .MEM_READY_I(mem_rdy), .LOADER_MASTER_CLEAR_O(mc), .LOADER_GO_O(go),
    .PROTECT_OVERRIDE_O(ovr), .REG_ADDR_I(ra), .REG_WDATA_I(wd),
    .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdat));
  pbl_host_model u_host (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
    .rom_rd_i(rom_rd), .rom_addr_i(rom_addr), .rom_data_o(rom_data),
    .mem_wr_i(mem_wr), .mem_word_i({ma, md}), .mem_ready_o(mem_rdy),
    .mc_i(mc), .go_i(go));
  function automatic logic [15:0] rw(input int a);
    return {a[9:0], 6'h15} ^ 16'h3c5a;
  endfunction : rw
  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge clk);
    ra <= a;
    wd <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge clk);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    v = rdat;
  endtask : reg_rd
  task automatic fire(input int k);
    case (k)
      0: loc <= 1'b1;
      1: rem_n <= 1'b0;
      2: con <= 1'b1;
      3: reg_wr(2'h0, 16'h0001);
      default: pwr <= 1'b0;
    endcase
    repeat (3) @(posedge clk);
    {loc, rem_n, con, pwr} <= 4'h5;
  endtask : fire
  task automatic run_case(input int i);
    int base, gb, mb, n, st, lim, tmo;
    logic [15:0] a, s, d;
    logic [7:0] c;
    pbl_pkg::pbl_mem_word_t exp[$];
    c = cfg[i];
    @(posedge clk);
    {en, clr_j, spb_j, go_j, pup_j, full, slow} <= c[6:0];
    a = 16'($urandom_range(32'hff00, 32'h0020));
    st = (i > 5) ? 508 : 4 * $urandom_range(100, 0);
    sel <= 8'(st / 4);
    {ahi, alo} <= a;
    base = u_host.wq.size();
    gb = u_host.n_go;
    mb = u_host.n_mc;
    fire(kd[i]);
    if (c[7]) begin
      repeat (100) @(posedge clk);
      fire(0);
    end else repeat (150) @(posedge clk);
    tmo = 0;
    do begin
      reg_rd(2'h1, d);
      tmo++;
    end while (d[0] !== 1'b0 && tmo < 3000);
    if (tmo >= 3000) begin
      n_fail++;
      report_and_stop();
    end
    if (c[7] && !c[5])
      for (int k = 0; k < 32; k++) exp.push_back('{16'(k), 16'h0});
    if (c[7] && !c[4])
      for (int k = 0; k < 4; k++) exp.push_back('{16'(k), rw(960 + k)});
    lim = c[1] ? 1024 : 512;
    n = (st >= lim) ? 0 : ((lim - st < 8) ? lim - st : 8);
    if (!c[7]) n = 0;
    s = 16'h0;
    for (int k = 0; k < n; k++) begin
      exp.push_back('{a + 16'(k), rw(st + k)});
      s += rw(st + k);
    end
    chk("writes", u_host.wq.size() - base, exp.size());
    foreach (exp[k]) chk("word", u_host.wq[base + k], exp[k]);
    chk("go", u_host.n_go - gb, c[7] & c[3]);
    chk("mclr", u_host.n_mc - mb, c[7]);
    if (c[7]) begin
      reg_rd(2'h2, d);
      chk("sum", d, s);
      reg_rd(2'h3, d);
      chk("next", d, a + 16'(n));
    end
  endtask : run_case
  initial begin
    void'($urandom(32'h28b164e2));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (150) @(posedge clk);
    chk("idle", u_host.wq.size(), 0);
    for (int i = 0; i < 8; i++) run_case(i);
    report_and_stop();
  end
endmodule : pbl_loader_tb_top
`default_nettype wire
